// *** verilog/gis_cfg.svh ***
`ifndef GIS_CFG_SVH
`define GIS_CFG_SVH

// ----------------------------------------------------------------------------
// pin layout
// ----------------------------------------------------------------------------
`define GIS_NUM_X          8
`define GIS_NUM_Y          12
`define GIS_NUM_PINS       20
`define GIS_Y_LOW_LSB      8
`define GIS_Y_HIGH_LSB     16
`define GIS_Y_HIGH_WIDTH   4

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define GIS_ADDR_BOTH_X    8'hCC
`define GIS_ADDR_BOTH_YL   8'hCD
`define GIS_ADDR_BOTH_YH   8'hCE
`define GIS_ADDR_POL_X     8'hCF
`define GIS_ADDR_POL_YL    8'hD0
`define GIS_ADDR_POL_YH    8'hD1
`define GIS_ADDR_EN_X      8'hD2
`define GIS_ADDR_EN_YL     8'hD3
`define GIS_ADDR_EN_YH     8'hD4
`define GIS_ADDR_RAW_X     8'hD6
`define GIS_ADDR_RAW_YL    8'hD7
`define GIS_ADDR_RAW_YH    8'hD8
`define GIS_ADDR_MSK_X     8'hD9
`define GIS_ADDR_MSK_YL    8'hDA
`define GIS_ADDR_MSK_YH    8'hDB
`define GIS_ADDR_CLR_X     8'hDC
`define GIS_ADDR_CLR_YL    8'hDD
`define GIS_ADDR_CLR_YH    8'hDE
`define GIS_ADDR_WAKE_X    8'hE9

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define GIS_RST_RAW        20'h00000
`define GIS_RST_EN         20'h00000
`define GIS_RST_POL        20'hFFFFF
`define GIS_RST_BOTH       20'h00000
`define GIS_RST_WAKE       8'h00
`define GIS_RST_RDATA      8'h00

`endif

// *** verilog/gis_pkg.sv ***
`include "gis_cfg.svh"

package gis_pkg;

  // one-hot selector of the three 8-bit register groups
  typedef enum logic [2:0] {
    GIS_GRP_NONE = 3'b000,
    GIS_GRP_X    = 3'b001,
    GIS_GRP_YL   = 3'b010,
    GIS_GRP_YH   = 3'b100
  } gis_grp_e;

  typedef logic [`GIS_NUM_PINS-1:0] gis_pins_t;
  typedef logic [7:0]               gis_byte_t;

endpackage

// *** verilog/gis_pin_if.sv ***
`timescale 1ns/1ps

interface gis_pin_if #(
  parameter int NPINS = 20
);
  logic [NPINS-1:0] pinLevel;
  logic [NPINS-1:0] polarity;
  logic [NPINS-1:0] bothEdge;
  logic [NPINS-1:0] edgeHit;
  logic [NPINS-1:0] activity;

  modport detect (
    input  pinLevel,
    input  polarity,
    input  bothEdge,
    output edgeHit,
    output activity
  );

  modport ctrl (
    output pinLevel,
    output polarity,
    output bothEdge,
    input  edgeHit,
    input  activity
  );
endinterface

// *** verilog/gis_pin_detect.sv ***
`timescale 1ns/1ps

module gis_pin_detect #(
  parameter int NPINS = 20
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  gis_pin_if.detect pins
);

  generate
    if (NPINS < 1) begin : g_bad_npins
      $error("gis_pin_detect: NPINS must be at least 1");
    end
  endgenerate

  logic [NPINS-1:0] prevLevel;
  logic             primed;

  // ---------------------------------------------------------------------------
  // previous level
  // ---------------------------------------------------------------------------
  // primed keeps the first sample after reset from looking like an edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevLevel <= '0;
    end else begin
      prevLevel <= pins.pinLevel;
    end
  end

  // ---------------------------------------------------------------------------
  // per-pin edge selection
  // ---------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = primed & pins.pinLevel[i] & ~prevLevel[i];
      assign fall = primed & ~pins.pinLevel[i] & prevLevel[i];
      assign pins.activity[i] = rise | fall;
      assign pins.edgeHit[i]  = pins.bothEdge[i] ? (rise | fall) :
                                pins.polarity[i] ? rise : fall;
    end
  endgenerate

endmodule

// *** verilog/gis_irq_status.sv ***
`timescale 1ns/1ps
`include "gis_cfg.svh"

// How it works
// - write one clears matching X pin interrupt
// - write one clears Y pins 0-7 interrupt
// - bits 3:0 clear Y 8-11; rest reserved
// - X raw status read-only, resets zero
// - Y low raw status read-only, resets zero
// - Y high raw status bits 3:0, reset zero
// - X masked status read-only, resets zero
// - Y low masked status read-only, resets zero
// - Y high masked status bits 3:0, reset zero
// - X wake bit lets pin wake device
// - X wake enables reset to zero
// - interrupt enable per pin, reset zero
// - polarity one rising, zero falling; reset ones
// - both-edge bit triggers on either edge
module gis_irq_status #(
  parameter int NUM_X = 8,
  parameter int NUM_Y = 12
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [NUM_X-1:0]      matrixXPins,
  input  wire logic [NUM_Y-1:0]      matrixYPins,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  output logic      [7:0]            regRdData,
  output logic                       regRdAck,
  output logic                       irqOut,
  output logic                       wakeUp
);

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  // the register map has fixed byte groups, so other pin counts cannot be served
  generate
    if (NUM_X != `GIS_NUM_X || NUM_Y != `GIS_NUM_Y) begin : g_bad_size
      $error("gis_irq_status: register map serves exactly 8 X and 12 Y pins");
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // group helpers
  // ---------------------------------------------------------------------------
  // byte view of one register group of a 20-bit field
  function automatic gis_pkg::gis_byte_t groupByte(input gis_pkg::gis_pins_t vec,
                                                   input gis_pkg::gis_grp_e grp);
    gis_pkg::gis_byte_t res;
    res = 8'h00;
    case (grp)
      gis_pkg::GIS_GRP_X:  res = vec[`GIS_Y_LOW_LSB-1:0];
      gis_pkg::GIS_GRP_YL: res = vec[`GIS_Y_HIGH_LSB-1:`GIS_Y_LOW_LSB];
      // reserved upper nibble reads as zero
      gis_pkg::GIS_GRP_YH: res = {4'h0, vec[`GIS_NUM_PINS-1:`GIS_Y_HIGH_LSB]};
      default:             res = 8'h00;
    endcase
    return res;
  endfunction

  function automatic gis_pkg::gis_pins_t groupMask(input gis_pkg::gis_byte_t data,
                                                   input gis_pkg::gis_grp_e grp);
    gis_pkg::gis_pins_t res;
    res = '0;
    case (grp)
      gis_pkg::GIS_GRP_X:  res[`GIS_Y_LOW_LSB-1:0] = data;
      gis_pkg::GIS_GRP_YL: res[`GIS_Y_HIGH_LSB-1:`GIS_Y_LOW_LSB] = data;
      gis_pkg::GIS_GRP_YH: res[`GIS_NUM_PINS-1:`GIS_Y_HIGH_LSB] = data[`GIS_Y_HIGH_WIDTH-1:0];
      default:             res = '0;
    endcase
    return res;
  endfunction

  // writes one group of a 20-bit field, other groups untouched
  function automatic gis_pkg::gis_pins_t groupWrite(input gis_pkg::gis_pins_t old,
                                                    input gis_pkg::gis_byte_t data,
                                                    input gis_pkg::gis_grp_e grp);
    gis_pkg::gis_pins_t sel;
    sel = groupMask(8'hFF, grp);
    return (old & ~sel) | (groupMask(data, grp) & sel);
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  gis_pkg::gis_pins_t rawStatus;
  gis_pkg::gis_pins_t intEnable;
  gis_pkg::gis_pins_t polarity;
  gis_pkg::gis_pins_t bothEdge;
  logic [NUM_X-1:0]   wakeEnable;
  gis_pkg::gis_pins_t maskedStatus;
  gis_pkg::gis_pins_t clearBits;
  gis_pkg::gis_pins_t next_rawStatus;
  gis_pkg::gis_byte_t next_regRdData;

  // edge detection lives in its own module, fed through the pin interface
  gis_pin_if #(.NPINS(`GIS_NUM_PINS)) pinBus ();

  assign pinBus.pinLevel = {matrixYPins, matrixXPins};
  assign pinBus.polarity = polarity;
  assign pinBus.bothEdge = bothEdge;

  gis_pin_detect #(
    .NPINS (`GIS_NUM_PINS)
  ) u_detect (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pins    (pinBus.detect)
  );

  // ---------------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------------
  // writes to status or unmapped addresses match nothing and are dropped
  logic wrClr;
  logic wrEn;
  logic wrPol;
  logic wrBoth;
  gis_pkg::gis_grp_e wrGrp;

  always_comb begin
    wrClr  = 1'b0;
    wrEn   = 1'b0;
    wrPol  = 1'b0;
    wrBoth = 1'b0;
    wrGrp  = gis_pkg::GIS_GRP_NONE;
    if (regAddr == `GIS_ADDR_CLR_X) begin
      wrClr = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_X;
    end else if (regAddr == `GIS_ADDR_CLR_YL) begin
      wrClr = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YL;
    end else if (regAddr == `GIS_ADDR_CLR_YH) begin
      wrClr = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YH;
    end else if (regAddr == `GIS_ADDR_EN_X) begin
      wrEn  = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_X;
    end else if (regAddr == `GIS_ADDR_EN_YL) begin
      wrEn  = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YL;
    end else if (regAddr == `GIS_ADDR_EN_YH) begin
      wrEn  = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YH;
    end else if (regAddr == `GIS_ADDR_POL_X) begin
      wrPol = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_X;
    end else if (regAddr == `GIS_ADDR_POL_YL) begin
      wrPol = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YL;
    end else if (regAddr == `GIS_ADDR_POL_YH) begin
      wrPol = 1'b1;
      wrGrp = gis_pkg::GIS_GRP_YH;
    end else if (regAddr == `GIS_ADDR_BOTH_X) begin
      wrBoth = 1'b1;
      wrGrp  = gis_pkg::GIS_GRP_X;
    end else if (regAddr == `GIS_ADDR_BOTH_YL) begin
      wrBoth = 1'b1;
      wrGrp  = gis_pkg::GIS_GRP_YL;
    end else if (regAddr == `GIS_ADDR_BOTH_YH) begin
      wrBoth = 1'b1;
      wrGrp  = gis_pkg::GIS_GRP_YH;
    end
  end

  // clear register bits are strobes only; the reserved nibble is dropped by groupMask
  assign clearBits = (regWrEn && wrClr) ? groupMask(regWrData, wrGrp) : '0;

  // ---------------------------------------------------------------------------
  // raw and masked status
  // ---------------------------------------------------------------------------
  // a new edge in the clearing cycle survives, so no event is lost
  assign next_rawStatus = (rawStatus & ~clearBits) | pinBus.edgeHit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rawStatus <= `GIS_RST_RAW;
    end else begin
      rawStatus <= next_rawStatus;
    end
  end

  // combinational, so enabling a pin later exposes edges it saw while masked
  assign maskedStatus = rawStatus & intEnable;

  // registered so the request line cannot glitch while status bits settle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |maskedStatus;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // reserved nibbles of the Y high group are masked off inside groupWrite
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intEnable <= `GIS_RST_EN;
    end else if (regWrEn && wrEn) begin
      intEnable <= groupWrite(intEnable, regWrData, wrGrp);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      polarity <= `GIS_RST_POL;
    end else if (regWrEn && wrPol) begin
      polarity <= groupWrite(polarity, regWrData, wrGrp);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bothEdge <= `GIS_RST_BOTH;
    end else if (regWrEn && wrBoth) begin
      bothEdge <= groupWrite(bothEdge, regWrData, wrGrp);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeEnable <= `GIS_RST_WAKE;
    end else if (regWrEn && regAddr == `GIS_ADDR_WAKE_X) begin
      wakeEnable <= regWrData;
    end
  end

  // ---------------------------------------------------------------------------
  // wake-up
  // ---------------------------------------------------------------------------
  // any level change counts as activity, independent of interrupt enables
  // wakeUp is a one-cycle pulse; the sleep logic must latch it itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeUp <= 1'b0;
    end else begin
      wakeUp <= |(pinBus.activity[NUM_X-1:0] & wakeEnable);
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // clear registers, reserved bits and unmapped addresses read as zero
  always_comb begin
    next_regRdData = `GIS_RST_RDATA;
    if (regAddr == `GIS_ADDR_RAW_X) begin
      next_regRdData = groupByte(rawStatus, gis_pkg::GIS_GRP_X);
    end else if (regAddr == `GIS_ADDR_RAW_YL) begin
      next_regRdData = groupByte(rawStatus, gis_pkg::GIS_GRP_YL);
    end else if (regAddr == `GIS_ADDR_RAW_YH) begin
      next_regRdData = groupByte(rawStatus, gis_pkg::GIS_GRP_YH);
    end else if (regAddr == `GIS_ADDR_MSK_X) begin
      next_regRdData = groupByte(maskedStatus, gis_pkg::GIS_GRP_X);
    end else if (regAddr == `GIS_ADDR_MSK_YL) begin
      next_regRdData = groupByte(maskedStatus, gis_pkg::GIS_GRP_YL);
    end else if (regAddr == `GIS_ADDR_MSK_YH) begin
      next_regRdData = groupByte(maskedStatus, gis_pkg::GIS_GRP_YH);
    end else if (regAddr == `GIS_ADDR_EN_X) begin
      next_regRdData = groupByte(intEnable, gis_pkg::GIS_GRP_X);
    end else if (regAddr == `GIS_ADDR_EN_YL) begin
      next_regRdData = groupByte(intEnable, gis_pkg::GIS_GRP_YL);
    end else if (regAddr == `GIS_ADDR_EN_YH) begin
      next_regRdData = groupByte(intEnable, gis_pkg::GIS_GRP_YH);
    end else if (regAddr == `GIS_ADDR_POL_X) begin
      next_regRdData = groupByte(polarity, gis_pkg::GIS_GRP_X);
    end else if (regAddr == `GIS_ADDR_POL_YL) begin
      next_regRdData = groupByte(polarity, gis_pkg::GIS_GRP_YL);
    end else if (regAddr == `GIS_ADDR_POL_YH) begin
      next_regRdData = groupByte(polarity, gis_pkg::GIS_GRP_YH);
    end else if (regAddr == `GIS_ADDR_BOTH_X) begin
      next_regRdData = groupByte(bothEdge, gis_pkg::GIS_GRP_X);
    end else if (regAddr == `GIS_ADDR_BOTH_YL) begin
      next_regRdData = groupByte(bothEdge, gis_pkg::GIS_GRP_YL);
    end else if (regAddr == `GIS_ADDR_BOTH_YH) begin
      next_regRdData = groupByte(bothEdge, gis_pkg::GIS_GRP_YH);
    end else if (regAddr == `GIS_ADDR_WAKE_X) begin
      next_regRdData = wakeEnable;
    end
  end

  // the host learns the pending pins from a masked read before clearing them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= `GIS_RST_RDATA;
      regRdAck  <= 1'b0;
    end else begin
      regRdAck <= regRdEn;
      if (regRdEn) begin
        regRdData <= next_regRdData;
      end
    end
  end

endmodule

// *** tb/gis_irq_status_checker.sv ***
`timescale 1ns/1ps

module gis_irq_status_checker #(
  parameter int NUM_X = 8,
  parameter int NUM_Y = 12
) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [NUM_X-1:0] matrixXPins,
  input wire logic             regWrEn,
  input wire logic             regRdEn,
  input wire logic [7:0]       regAddr,
  input wire logic [7:0]       regWrData,
  input wire logic [7:0]       regRdData,
  input wire logic             regRdAck,
  input wire logic             irqOut,
  input wire logic             wakeUp
);
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  logic [7:0] wakeReg;
  logic       enSeen;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeReg <= 8'h00;
    end else if (regWrEn && regAddr == 8'hE9) begin
      wakeReg <= regWrData;
    end
  end

  // sticky: no enable ever written means no pin may reach the irq line
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enSeen <= 1'b0;
    end else if (regWrEn && regAddr inside {8'hD2, 8'hD3, 8'hD4} && regWrData != 8'h00) begin
      enSeen <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_wake_wr;
    regWrEn && regAddr == 8'hE9;
  endsequence
  sequence s_wake_rd;
    regRdEn && !regWrEn && regAddr == 8'hE9;
  endsequence

  a_read_ack_next: assert property (regRdEn |=> regRdAck)
    else $error("read not acknowledged next cycle");
  a_ack_only_read: assert property (regRdAck |-> $past(regRdEn))
    else $error("acknowledge without read");
  a_data_holds: assert property (!$past(regRdEn) |-> $stable(regRdData))
    else $error("read data moved without read");
  a_clear_reads_zero: assert property (
    regRdEn && regAddr inside {8'hDC, 8'hDD, 8'hDE} |=> regRdData == 8'h00)
    else $error("clear register read not zero");
  a_ryh_upper_zero: assert property (
    regRdEn && regAddr == 8'hD8 |=> regRdData[7:4] == 4'h0)
    else $error("raw high reserved bits set");
  a_myh_upper_zero: assert property (
    regRdEn && regAddr == 8'hDB |=> regRdData[7:4] == 4'h0)
    else $error("masked high reserved bits set");
  a_wake_reads_back: assert property (
    s_wake_wr ##1 !regWrEn ##1 s_wake_rd |=> regRdData == $past(regWrData, 3))
    else $error("wake register read back wrong");
  a_wake_on_change: assert property (
    ((matrixXPins ^ $past(matrixXPins)) & wakeReg) != 8'h00 |-> ##[0:2] wakeUp)
    else $error("wake pulse missing");
  a_wake_needs_bit: assert property (wakeReg == 8'h00 |=> !wakeUp)
    else $error("wake pulse with no wake bit");
  a_irq_needs_en: assert property (!enSeen |-> !irqOut)
    else $error("irq with no enable written");
endmodule

bind gis_irq_status gis_irq_status_checker #(.NUM_X(NUM_X), .NUM_Y(NUM_Y)) u_chk (
  .clk        (clk),
  .sys_rst    (sys_rst),
  .matrixXPins(matrixXPins),
  .regWrEn    (regWrEn),
  .regRdEn    (regRdEn),
  .regAddr    (regAddr),
  .regWrData  (regWrData),
  .regRdData  (regRdData),
  .regRdAck   (regRdAck),
  .irqOut     (irqOut),
  .wakeUp     (wakeUp)
);

// *** tb/gis_host_model.sv ***
`timescale 1ns/1ps

module gis_host_model (
  input  wire logic       clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // clear writes follow a status read in the caller's sequence
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(posedge clk);
    @(negedge clk);
    regWrEn   = 1'b0;
    // released lines show garbage, not the last value
    regAddr   = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask
endmodule

// *** tb/gis_irq_status_bench.sv ***
`timescale 1ns/1ps

module gis_irq_status_bench;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} gis_row_s;

  logic        clk;
  logic        sys_rst;
  logic [7:0]  xPins;
  logic [11:0] yPins;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic        regRdAck;
  logic        irqOut;
  logic        wakeUp;
  int          errCount;
  int          checksDone;
  int          wakeCnt;
  gis_row_s    rows [15];

  gis_irq_status u_dut (
    .clk(clk), .sys_rst(sys_rst), .matrixXPins(xPins), .matrixYPins(yPins),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdAck(regRdAck), .irqOut(irqOut), .wakeUp(wakeUp));

  gis_host_model u_host (
    .clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // wakeUp launches on a rising edge, so the falling edge sees it settled
  always @(negedge clk) begin
    if (sys_rst) begin
      wakeCnt <= 0;
    end else if (wakeUp === 1'b1) begin
      wakeCnt <= wakeCnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    check(d, exp);
  endtask

  // one idle cycle after the change lets the edge land in raw status
  task automatic pins(input logic [7:0] x, input logic [11:0] y);
    @(negedge clk);
    xPins = x;
    yPins = y;
    @(negedge clk);
  endtask

  // called at time zero or just after a falling edge; holds reset over six rising edges, seven in all
  task automatic reset_dut();
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
  endtask

  task automatic run_table();
    foreach (rows[i]) begin
      rdchk(rows[i].a, rows[i].e);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    xPins = 8'h00;
    yPins = 12'h000;
    errCount = 0;
    checksDone = 0;
    rows = '{'{8'hCC, 8'h00}, '{8'hCE, 8'h00}, '{8'hCF, 8'hFF}, '{8'hD1, 8'h0F},
             '{8'hD2, 8'h00}, '{8'hD4, 8'h00}, '{8'hD6, 8'h00}, '{8'hD7, 8'h00},
             '{8'hD8, 8'h00}, '{8'hD9, 8'h00}, '{8'hDA, 8'h00}, '{8'hDB, 8'h00},
             '{8'hDC, 8'h00}, '{8'hE9, 8'h00}, '{8'h00, 8'h00}};
    reset_dut();
    run_table();
    u_host.wr(8'hD2, 8'h01);
    pins(8'h03, 12'h000);
    rdchk(8'hD6, 8'h03);
    rdchk(8'hD9, 8'h01);
    check({7'h00, irqOut}, 8'h01);
    u_host.wr(8'hD6, 8'h00);
    rdchk(8'hD6, 8'h03);
    u_host.wr(8'hDC, 8'h02);
    rdchk(8'hD6, 8'h01);
    u_host.wr(8'hDC, 8'h01);
    rdchk(8'hD6, 8'h00);
    check({7'h00, irqOut}, 8'h00);
    u_host.wr(8'hD0, 8'h00);
    pins(8'h03, 12'h001);
    rdchk(8'hD7, 8'h00);
    pins(8'h03, 12'h000);
    rdchk(8'hD7, 8'h01);
    u_host.wr(8'hD3, 8'h01);
    rdchk(8'hDA, 8'h01);
    u_host.wr(8'hDD, 8'h01);
    rdchk(8'hD7, 8'h00);
    u_host.wr(8'hCE, 8'h0F);
    u_host.wr(8'hD4, 8'hFF);
    rdchk(8'hD4, 8'h0F);
    pins(8'h03, 12'h100);
    rdchk(8'hD8, 8'h01);
    rdchk(8'hDB, 8'h01);
    u_host.wr(8'hDE, 8'hFF);
    rdchk(8'hD8, 8'h00);
    pins(8'h03, 12'h000);
    rdchk(8'hD8, 8'h01);
    u_host.wr(8'hDE, 8'h01);
    rdchk(8'hD8, 8'h00);
    u_host.wr(8'hE9, 8'h04);
    rdchk(8'hE9, 8'h04);
    pins(8'h07, 12'h000);
    pins(8'h0F, 12'h000);
    check(wakeCnt[7:0], 8'h01);
    reset_dut();
    run_table();
    check({7'h00, irqOut}, 8'h00);
    printVerdict();
  end

  // about 145 cycles of traffic; the limit leaves wide margin
  initial begin
    #200000;
    errCount++;
    printVerdict();
  end
endmodule
